/* src/spu_pkg.sv */
// Constants, register map, memory layout and state encoding for the semaphore and preemption unit
package spu_pkg;
   // Register byte offsets on the AHB-Lite slave
   localparam logic [7:0] REG_CMD = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_FLAGS = 8'h08;
   localparam logic [7:0] REG_SEM_BASE = 8'h0c;
   localparam logic [7:0] REG_DISP_BASE = 8'h10;
   localparam logic [7:0] REG_CUR_PROC = 8'h14;
   localparam logic [7:0] REG_CUR_PRIO = 8'h18;
   localparam logic [7:0] REG_WOKEN = 8'h1c;
   // Command codes written to the command register
   localparam logic [2:0] OP_SIGNAL = 3'h1;
   localparam logic [2:0] OP_WAIT = 3'h2;
   localparam logic [2:0] OP_CONDWAIT = 3'h3;
   localparam logic [2:0] OP_PREEMPT_MSG = 3'h4;
   localparam logic [2:0] OP_RET_INTR = 3'h5;
   // Status and flag field positions
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_CC_LSB = 4;
   localparam int STAT_CHKDISP_BIT = 8;
   localparam int STAT_INTR_BIT = 9;
   localparam int FLAG_INTR_BIT = 0;
   localparam int FLAG_CHKDISP_BIT = 1;
   // Shared-memory layout of a semaphore
   localparam int LOCK_BIT = 0;
   localparam logic [31:0] SEM_OFS_LOCK = 32'h0000_0000;
   localparam logic [31:0] SEM_OFS_COUNT = 32'h0000_0004;
   localparam logic [31:0] SEM_OFS_TAIL = 32'h0000_0008;
   localparam logic [31:0] LOCK_SET = 32'h0000_0001;
   localparam logic [31:0] LOCK_FREE = 32'h0000_0000;
   // Process control block layout, one block per selector
   localparam int PROC_SHIFT = 6;
   localparam logic [31:0] PROC_OFS_LINK = 32'h0000_0000;
   localparam logic [31:0] PROC_OFS_CTRL = 32'h0000_0004;
   localparam int PREEMPT_BIT = 5;
   localparam int NUM_PRIO = 32;
   localparam logic [4:0] PRIO_TOP = 5'h1f;
   // Condition codes after a conditional wait
   localparam logic [2:0] CC_SIGNALLED = 3'h2;
   localparam logic [2:0] CC_NONE = 3'h0;
   localparam logic [15:0] SEL_NONE = 16'h0000;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;

   typedef enum logic [4:0] {
      ST_IDLE, ST_LOCK, ST_LOCK_CHK, ST_SIG_TAIL, ST_SIG_CNT, ST_SIG_HEAD, ST_SIG_HLINK,
      ST_SIG_RDCTL, ST_SIG_CTL, ST_CNT, ST_WQ_TAIL, ST_WQ_NEXT, ST_WQ_CMP, ST_WQ_INS1,
      ST_WQ_INS2, ST_UNLOCK, ST_AFTER_UNLOCK, ST_PRE_CHECK, ST_DE_T, ST_DE_H, ST_DE_LT,
      ST_DE_SETT, ST_DS_START, ST_DS_CHK, ST_DS_DEQ, ST_DS_HEAD, ST_DS_HL, ST_DS_BIND,
      ST_DS_PRIO, ST_FINISH
   } spu_state_e;
endpackage

/* src/spu_semaphore_preemption_unit.sv */
// Semaphore signal/wait/condwait engine with process preemption and an AHB-Lite control slave
`timescale 1ns/1ps
`default_nettype none

// Function
// [R1] Spin on lock bit until acquired
// [R2] Count is unsigned 16 bits
// [R3] Tail holds last selector, zero when empty
// [R4] Queue ordered by priority, FIFO among equals
// [R5] Circular queue, last links to first
// [R6] Signal locks, then reads queue tail
// [R7] Signal on empty queue increments count
// [R8] Signal otherwise wakes head, reschedules it
// [R9] Wait with count decrements and continues
// [R10] Wait without count suspends, queues, dispatches
// [R11] Condwait decrements or leaves semaphore alone
// [R12] Condwait sets code 010 or 000
// [R13] Preemption from unblock or remote message
// [R14] Preempting process enqueued at dispatch first
// [R15] Interrupted: set check-dispatch flag, stop
// [R16] Interrupt return checks port, dispatches higher
// [R17] Lower or equal priority: no preemption
// [R18] Higher: requeue current at head, dispatch
// [R19] Software sets preempt flags above threshold
// [R20] Dispatch takes head of highest queue
// [R21] Dispatch port holds 32 priority queues
// [R22] Lock test-and-set is one atomic access
// [R23] Lock cleared as final semaphore write
module spu_semaphore_preemption_unit (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   output logic memReq,
   output logic [31:0] memAddr,
   output logic memWrite,
   output logic memAtomic,
   output logic [31:0] memWdata,
   input wire logic memAck,
   input wire logic [31:0] memRdata
);
   import spu_pkg::*;

   typedef struct packed {
      spu_state_e st;
      spu_state_e qRet;
      logic [2:0] op;
      logic busy;
      logic memReq;
      logic memWrite;
      logic memAtomic;
      logic [31:0] memAddr;
      logic [31:0] memWdata;
      logic [31:0] rd;
      logic [15:0] tail;
      logic [15:0] head;
      logic [15:0] walk;
      logic [15:0] prev;
      logic [15:0] woken;
      logic [15:0] qItem;
      logic [15:0] curProc;
      logic [4:0] wokePrio;
      logic [4:0] qPrio;
      logic [4:0] scanPrio;
      logic [4:0] curPrio;
      logic wokePreempt;
      logic qAtHead;
      logic setTail;
      logic condScan;
      logic waitSusp;
      logic intr;
      logic chkDisp;
      logic [2:0] cc;
      logic [31:0] semBase;
      logic [31:0] dispBase;
      logic hWrPend;
      logic hHit;
      logic [7:0] hAddr;
      logic [31:0] hrdata;
      logic hreadyout;
      logic hresp;
   } spu_s;

   spu_s r;
   spu_s n;

   function automatic logic [31:0] procAddr(input logic [15:0] sel, input logic [31:0] ofs);
      logic [31:0] a;
      a = {16'h0000, sel} << PROC_SHIFT;
      return a + ofs;
   endfunction

   // One 32-bit tail word per priority level
   function automatic logic [31:0] dispAddr(input logic [31:0] base, input logic [4:0] prio);
      return base + {25'h0, prio, 2'b00}; // [R21]
   endfunction

   function automatic spu_s issue(input spu_s s, input logic [31:0] a, input logic w,
                                  input logic [31:0] d, input spu_state_e nx);
      spu_s t;
      t = s;
      t.memReq = 1'b1;
      t.memAddr = a;
      t.memWrite = w;
      t.memAtomic = 1'b0;
      t.memWdata = d;
      t.st = nx;
      return t;
   endfunction

   function automatic logic [31:0] readReg(input spu_s s, input logic [7:0] a, input logic hit);
      logic [31:0] v;
      v = RST_WORD;
      if (!hit) begin
         v = RST_WORD;
      end else if (a == REG_CMD) begin
         v = {29'h0, s.op};
      end else if (a == REG_STATUS) begin
         v = ({31'h0, s.busy} << STAT_BUSY_BIT) | ({29'h0, s.cc} << STAT_CC_LSB) |
             ({31'h0, s.chkDisp} << STAT_CHKDISP_BIT) | ({31'h0, s.intr} << STAT_INTR_BIT);
      end else if (a == REG_FLAGS) begin
         v = ({31'h0, s.intr} << FLAG_INTR_BIT) | ({31'h0, s.chkDisp} << FLAG_CHKDISP_BIT);
      end else if (a == REG_SEM_BASE) begin
         v = s.semBase;
      end else if (a == REG_DISP_BASE) begin
         v = s.dispBase;
      end else if (a == REG_CUR_PROC) begin
         v = {16'h0, s.curProc};
      end else if (a == REG_CUR_PRIO) begin
         v = {27'h0, s.curPrio};
      end else if (a == REG_WOKEN) begin
         v = {16'h0, s.woken};
      end
      return v;
   endfunction

   always_comb begin
      n = r;
      // A state only runs once the previous memory access has been acknowledged
      if (r.memReq) begin
         if (memAck) begin
            n.memReq = 1'b0;
            n.memAtomic = 1'b0;
            n.rd = memRdata;
         end
      end else begin
         case (r.st)
            ST_IDLE: begin
               if (r.busy) begin
                  if (r.op == OP_SIGNAL || r.op == OP_WAIT || r.op == OP_CONDWAIT) begin
                     n.st = ST_LOCK;
                  end else if (r.op == OP_PREEMPT_MSG) begin
                     n.st = ST_PRE_CHECK; // [R13]
                  end else if (r.op == OP_RET_INTR) begin
                     n.intr = 1'b0;
                     if (r.chkDisp) begin
                        n.chkDisp = 1'b0;
                        n.condScan = 1'b1;
                        n.st = ST_DS_START; // [R16]
                     end else begin
                        n.st = ST_FINISH;
                     end
                  end else begin
                     n.st = ST_FINISH;
                  end
               end
            end
            ST_LOCK: begin
               n = issue(r, r.semBase + SEM_OFS_LOCK, 1'b0, LOCK_SET, ST_LOCK_CHK);
               n.memAtomic = 1'b1; // [R22]
            end
            ST_LOCK_CHK: begin
               if (r.rd[LOCK_BIT]) begin
                  n.st = ST_LOCK; // [R1]
               end else if (r.op == OP_SIGNAL) begin
                  n = issue(r, r.semBase + SEM_OFS_TAIL, 1'b0, RST_WORD, ST_SIG_TAIL); // [R6]
               end else begin
                  n = issue(r, r.semBase + SEM_OFS_COUNT, 1'b0, RST_WORD, ST_CNT);
               end
            end
            ST_SIG_TAIL: begin
               n.tail = r.rd[15:0];
               if (r.rd[15:0] == SEL_NONE) begin
                  n = issue(n, r.semBase + SEM_OFS_COUNT, 1'b0, RST_WORD, ST_SIG_CNT);
               end else begin
                  n = issue(n, procAddr(r.rd[15:0], PROC_OFS_LINK), 1'b0, RST_WORD, ST_SIG_HEAD);
               end
            end
            ST_SIG_CNT: begin
               n = issue(r, r.semBase + SEM_OFS_COUNT, 1'b1, {16'h0, r.rd[15:0] + 16'h1}, ST_UNLOCK); // [R7] [R2]
            end
            ST_SIG_HEAD: begin
               n.head = r.rd[15:0];
               if (r.rd[15:0] == r.tail) begin
                  n = issue(n, r.semBase + SEM_OFS_TAIL, 1'b1, RST_WORD, ST_SIG_RDCTL); // [R3]
               end else begin
                  n = issue(n, procAddr(r.rd[15:0], PROC_OFS_LINK), 1'b0, RST_WORD, ST_SIG_HLINK);
               end
            end
            ST_SIG_HLINK: begin
               n = issue(r, procAddr(r.tail, PROC_OFS_LINK), 1'b1, r.rd, ST_SIG_RDCTL); // [R5] [R8]
            end
            ST_SIG_RDCTL: begin
               n = issue(r, procAddr(r.head, PROC_OFS_CTRL), 1'b0, RST_WORD, ST_SIG_CTL);
            end
            ST_SIG_CTL: begin
               n.woken = r.head;
               n.wokePrio = r.rd[4:0];
               n.wokePreempt = r.rd[PREEMPT_BIT];
               n.qItem = r.head;
               n.qPrio = r.rd[4:0];
               n.qAtHead = 1'b0;
               n.qRet = ST_UNLOCK;
               n = issue(n, dispAddr(r.dispBase, r.rd[4:0]), 1'b0, RST_WORD, ST_DE_T); // [R8] [R14]
            end
            ST_CNT: begin
               if (r.rd[15:0] != 16'h0) begin
                  if (r.op == OP_CONDWAIT) begin
                     n.cc = CC_SIGNALLED; // [R12]
                  end
                  n = issue(n, r.semBase + SEM_OFS_COUNT, 1'b1, {16'h0, r.rd[15:0] - 16'h1}, ST_UNLOCK); // [R9] [R11]
               end else if (r.op == OP_CONDWAIT) begin
                  n.cc = CC_NONE; // [R11] [R12]
                  n.st = ST_UNLOCK;
               end else begin
                  n.waitSusp = 1'b1; // [R10]
                  n = issue(n, r.semBase + SEM_OFS_TAIL, 1'b0, RST_WORD, ST_WQ_TAIL);
               end
            end
            ST_WQ_TAIL: begin
               n.tail = r.rd[15:0];
               n.prev = r.rd[15:0];
               if (r.rd[15:0] == SEL_NONE) begin
                  n.walk = r.curProc;
                  n.prev = r.curProc;
                  n.setTail = 1'b1;
                  n.st = ST_WQ_INS1;
               end else begin
                  n.setTail = 1'b0;
                  n = issue(n, procAddr(r.rd[15:0], PROC_OFS_LINK), 1'b0, RST_WORD, ST_WQ_NEXT);
               end
            end
            ST_WQ_NEXT: begin
               n.walk = r.rd[15:0];
               if (r.prev == r.tail) begin
                  n.head = r.rd[15:0];
               end
               n = issue(n, procAddr(r.rd[15:0], PROC_OFS_CTRL), 1'b0, RST_WORD, ST_WQ_CMP);
            end
            ST_WQ_CMP: begin
               // Equal priority walks on, so newcomers land behind their peers
               if (r.rd[4:0] < r.curPrio) begin
                  n.st = ST_WQ_INS1; // [R4]
               end else if (r.walk == r.tail) begin
                  n.walk = r.head;
                  n.prev = r.tail;
                  n.setTail = 1'b1;
                  n.st = ST_WQ_INS1; // [R4]
               end else begin
                  n.prev = r.walk;
                  n = issue(n, procAddr(r.walk, PROC_OFS_LINK), 1'b0, RST_WORD, ST_WQ_NEXT);
               end
            end
            ST_WQ_INS1: begin
               n = issue(r, procAddr(r.curProc, PROC_OFS_LINK), 1'b1, {16'h0, r.walk}, ST_WQ_INS2); // [R5]
            end
            ST_WQ_INS2: begin
               if (r.setTail) begin
                  n.setTail = 1'b0;
                  n = issue(n, r.semBase + SEM_OFS_TAIL, 1'b1, {16'h0, r.curProc}, ST_UNLOCK); // [R3]
               end else begin
                  n = issue(r, procAddr(r.prev, PROC_OFS_LINK), 1'b1, {16'h0, r.curProc}, ST_UNLOCK);
               end
               if (r.setTail && r.prev != r.curProc) begin
                  n = issue(r, procAddr(r.prev, PROC_OFS_LINK), 1'b1, {16'h0, r.curProc}, ST_WQ_INS2);
                  n.prev = r.curProc;
               end
            end
            ST_UNLOCK: begin
               n = issue(r, r.semBase + SEM_OFS_LOCK, 1'b1, LOCK_FREE, ST_AFTER_UNLOCK); // [R23]
            end
            ST_AFTER_UNLOCK: begin
               if (r.op == OP_SIGNAL && r.wokePreempt) begin
                  n.st = ST_PRE_CHECK; // [R13]
               end else if (r.waitSusp) begin
                  n.condScan = 1'b0;
                  n.st = ST_DS_START; // [R10]
               end else begin
                  n.st = ST_FINISH;
               end
            end
            ST_PRE_CHECK: begin
               if (r.intr) begin
                  n.chkDisp = 1'b1; // [R15]
                  n.st = ST_FINISH;
               end else if (r.op == OP_SIGNAL && r.wokePrio <= r.curPrio) begin
                  n.st = ST_FINISH; // [R17]
               end else begin
                  n.condScan = 1'b1; // [R18]
                  n.st = ST_DS_START;
               end
            end
            ST_DE_T: begin
               n.walk = r.rd[15:0];
               if (r.rd[15:0] == SEL_NONE) begin
                  n = issue(n, procAddr(r.qItem, PROC_OFS_LINK), 1'b1, {16'h0, r.qItem}, ST_DE_SETT);
               end else begin
                  n = issue(n, procAddr(r.rd[15:0], PROC_OFS_LINK), 1'b0, RST_WORD, ST_DE_H);
               end
            end
            ST_DE_H: begin
               n = issue(r, procAddr(r.qItem, PROC_OFS_LINK), 1'b1, r.rd, ST_DE_LT);
            end
            ST_DE_LT: begin
               // Head insertion leaves the tail word untouched
               n = issue(r, procAddr(r.walk, PROC_OFS_LINK), 1'b1, {16'h0, r.qItem},
                         r.qAtHead ? r.qRet : ST_DE_SETT);
            end
            ST_DE_SETT: begin
               n = issue(r, dispAddr(r.dispBase, r.qPrio), 1'b1, {16'h0, r.qItem}, r.qRet);
            end
            ST_DS_START: begin
               n.scanPrio = PRIO_TOP;
               n = issue(n, dispAddr(r.dispBase, PRIO_TOP), 1'b0, RST_WORD, ST_DS_CHK);
            end
            ST_DS_CHK: begin
               if (r.rd[15:0] != SEL_NONE) begin
                  n.tail = r.rd[15:0];
                  if (!r.condScan || r.curProc == SEL_NONE) begin
                     n.st = ST_DS_DEQ; // [R20]
                  end else if (r.scanPrio > r.curPrio) begin
                     n.qItem = r.curProc;
                     n.qPrio = r.curPrio;
                     n.qAtHead = 1'b1;
                     n.qRet = ST_DS_DEQ;
                     n = issue(n, dispAddr(r.dispBase, r.curPrio), 1'b0, RST_WORD, ST_DE_T); // [R18]
                  end else begin
                     n.st = ST_FINISH; // [R16] [R17]
                  end
               end else if (r.scanPrio == 5'h0) begin
                  if (!r.condScan) begin
                     n.curProc = SEL_NONE;
                  end
                  n.st = ST_FINISH;
               end else begin
                  n.scanPrio = r.scanPrio - 5'h1;
                  n = issue(n, dispAddr(r.dispBase, r.scanPrio - 5'h1), 1'b0, RST_WORD, ST_DS_CHK); // [R20]
               end
            end
            ST_DS_DEQ: begin
               n = issue(r, procAddr(r.tail, PROC_OFS_LINK), 1'b0, RST_WORD, ST_DS_HEAD);
            end
            ST_DS_HEAD: begin
               n.head = r.rd[15:0];
               if (r.rd[15:0] == r.tail) begin
                  n = issue(n, dispAddr(r.dispBase, r.scanPrio), 1'b1, RST_WORD, ST_DS_BIND);
               end else begin
                  n = issue(n, procAddr(r.rd[15:0], PROC_OFS_LINK), 1'b0, RST_WORD, ST_DS_HL);
               end
            end
            ST_DS_HL: begin
               n = issue(r, procAddr(r.tail, PROC_OFS_LINK), 1'b1, r.rd, ST_DS_BIND);
            end
            ST_DS_BIND: begin
               n.curProc = r.head; // [R20]
               n = issue(n, procAddr(r.head, PROC_OFS_CTRL), 1'b0, RST_WORD, ST_DS_PRIO);
            end
            ST_DS_PRIO: begin
               n.curPrio = r.rd[4:0];
               n.st = ST_FINISH;
            end
            ST_FINISH: begin
               n.busy = 1'b0;
               n.st = ST_IDLE;
            end
            default: begin
               n.st = ST_IDLE;
            end
         endcase
      end

      // AHB-Lite data phase: writes land here; setup registers only change while idle
      if (r.hWrPend) begin
         n.hWrPend = 1'b0;
         if (r.hHit && !r.busy) begin
            if (r.hAddr == REG_CMD) begin
               n.op = hwdata[2:0];
               n.busy = 1'b1;
               n.wokePreempt = 1'b0;
               n.waitSusp = 1'b0;
            end else if (r.hAddr == REG_FLAGS) begin
               n.intr = hwdata[FLAG_INTR_BIT];
            end else if (r.hAddr == REG_SEM_BASE) begin
               n.semBase = hwdata;
            end else if (r.hAddr == REG_DISP_BASE) begin
               n.dispBase = hwdata;
            end else if (r.hAddr == REG_CUR_PROC) begin
               n.curProc = hwdata[15:0];
            end else if (r.hAddr == REG_CUR_PRIO) begin
               n.curPrio = hwdata[4:0];
            end
         end
      end
      // Address phase: read data is sampled now so it can leave from a flop
      if (hsel && htrans[1] && hready) begin
         n.hWrPend = hwrite;
         n.hAddr = haddr[7:0];
         n.hHit = (haddr[31:8] == 24'h0);
         if (!hwrite) begin
            n.hrdata = readReg(r, haddr[7:0], haddr[31:8] == 24'h0);
         end
      end
      n.hreadyout = 1'b1;
      n.hresp = 1'b0;
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         r <= '0;
         r.st <= ST_IDLE;
         r.hreadyout <= 1'b1;
      end else begin
         r <= n;
      end
   end

   assign hreadyout = r.hreadyout;
   assign hrdata = r.hrdata;
   assign hresp = r.hresp;
   assign memReq = r.memReq;
   assign memAddr = r.memAddr;
   assign memWrite = r.memWrite;
   assign memAtomic = r.memAtomic;
   assign memWdata = r.memWdata;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   sequence sRun(spu_state_e s);
      r.st == s && !r.memReq;
   endsequence
   sequence sWriteTo(logic [31:0] a);
      r.memReq && r.memWrite && r.memAddr == a;
   endsequence

   a_lock_retry: assert property ( // [R1]
      sRun(ST_LOCK_CHK) ##0 r.rd[LOCK_BIT] |=> r.st == ST_LOCK ##1 (r.memReq && r.memAtomic))
      else $error("lock not retried while held");
   a_lock_atomic: assert property ( // [R22]
      r.memReq && r.memAtomic |-> !r.memWrite && r.memWdata == LOCK_SET && r.memAddr == r.semBase)
      else $error("lock test-and-set malformed");
   a_count_incr: assert property ( // [R7]
      sRun(ST_SIG_CNT) |=> sWriteTo(r.semBase + SEM_OFS_COUNT) ##0
         r.memWdata[15:0] == $past(r.rd[15:0]) + 16'h1)
      else $error("signal did not increment count");
   a_count_decr: assert property ( // [R9]
      sRun(ST_CNT) ##0 r.rd[15:0] != 16'h0 |=> sWriteTo(r.semBase + SEM_OFS_COUNT) ##0
         r.memWdata[15:0] == $past(r.rd[15:0]) - 16'h1)
      else $error("wait did not decrement count");
   a_cond_code: assert property ( // [R12]
      sRun(ST_CNT) ##0 r.op == OP_CONDWAIT |=> r.cc == ($past(r.rd[15:0]) != 16'h0 ? CC_SIGNALLED : CC_NONE))
      else $error("wrong condition code after conditional wait");
   a_unlock_last: assert property ( // [R23]
      sRun(ST_UNLOCK) |=> sWriteTo(r.semBase + SEM_OFS_LOCK) ##0 r.memWdata == LOCK_FREE ##1 r.st == ST_AFTER_UNLOCK)
      else $error("unlock write missing");
   a_intr_defer: assert property ( // [R15]
      sRun(ST_PRE_CHECK) ##0 r.intr |=> r.chkDisp && r.st == ST_FINISH)
      else $error("interrupted preemption not deferred");
   a_no_preempt: assert property ( // [R17]
      sRun(ST_PRE_CHECK) ##0 (!r.intr && r.op == OP_SIGNAL && r.wokePrio <= r.curPrio) |=> r.st == ST_FINISH)
      else $error("preempted by lower or equal priority");
   a_scan_down: assert property ( // [R20]
      sRun(ST_DS_CHK) ##0 (r.rd[15:0] == SEL_NONE && r.scanPrio != 5'h0) |=> r.scanPrio == $past(r.scanPrio) - 5'h1)
      else $error("dispatch scan skipped a level");
   a_tail_clear: assert property ( // [R3]
      sRun(ST_SIG_HEAD) ##0 r.rd[15:0] == r.tail |=> sWriteTo(r.semBase + SEM_OFS_TAIL) ##0 r.memWdata == RST_WORD)
      else $error("tail not cleared when queue emptied");
endmodule

`default_nettype wire

/* verif/spu_mem_model.sv */
// Shared memory model with test-and-set and alternating answer speed
`timescale 1ns/1ps
`default_nettype none
module spu_mem_model (
   input wire logic sys_clk,
   input wire logic memReq,
   input wire logic [31:0] memAddr,
   input wire logic memWrite,
   input wire logic memAtomic,
   input wire logic [31:0] memWdata,
   output logic memAck,
   output logic [31:0] memRdata
);
   logic [31:0] mem [0:255];
   logic [31:0] rdat = 32'h0;
   logic [1:0] cnt = 2'h0;
   logic slow = 1'b0;
   initial memAck = 1'b0;
   // Unused tails start at zero, so queues start empty
   initial for (int i = 0; i < 256; i++) mem[i] = 32'h0;
   // Outside an ack the line no longer shows the last word
   assign memRdata = memAck ? rdat : ~rdat;
   always @(posedge sys_clk) begin
      memAck <= 1'b0;
      if (memReq && !memAck) begin
         if (cnt != 2'h0) begin
            cnt <= cnt - 2'h1;
         end else begin
            memAck <= 1'b1;
            slow <= ~slow;
            cnt <= slow ? 2'h0 : 2'h3;
            rdat <= mem[memAddr[9:2]];
            // Old word out and new word in at one edge
            if (memWrite || memAtomic) mem[memAddr[9:2]] <= memWdata;
         end
      end
   end
endmodule
`default_nettype wire

/* verif/spu_semaphore_preemption_unit_tb.sv */
// Register-level tests of the semaphore and preemption unit
`timescale 1ns/1ps
`default_nettype none
module spu_semaphore_preemption_unit_tb;
   import spu_pkg::*;
   logic sysClk = 1'b0, rstN = 1'b0, hwrite = 1'b0, hreadyout, hresp, memReq, memWrite, memAtomic, memAck;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, memAddr, memWdata, memRdata, q;
   int errTotal = 0;
   int nChecks = 0;
   always #20 sysClk = ~sysClk;
   spu_semaphore_preemption_unit dut (.sys_clk(sysClk), .rst_n(rstN), .hsel(1'b1), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .memReq(memReq), .memAddr(memAddr),
      .memWrite(memWrite), .memAtomic(memAtomic), .memWdata(memWdata), .memAck(memAck), .memRdata(memRdata));
   spu_mem_model m (.sys_clk(sysClk), .memReq(memReq), .memAddr(memAddr), .memWrite(memWrite),
      .memAtomic(memAtomic), .memWdata(memWdata), .memAck(memAck), .memRdata(memRdata));
   task automatic endOfTest;
      $display("checks %0d errors %0d", nChecks, errTotal);
      if (errTotal == 0 && nChecks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      nChecks++;
      if (seen !== exp) begin
         errTotal++;
         $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge sysClk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge sysClk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      chk(q, exp);
   endtask
   task automatic fin;
      int n;
      n = 0;
      do begin
         xfer(1'b0, REG_STATUS, 32'h0);
         n++;
      end while (q[STAT_BUSY_BIT] !== 1'b0 && n < 500);
      chk({30'h0, hresp, q[STAT_BUSY_BIT]}, 32'h0);
   endtask
   task automatic op(input logic [2:0] c);
      xfer(1'b1, REG_CMD, {29'h0, c});
      fin;
   endtask
   task automatic cm(input logic [9:0] a, input logic [31:0] exp);
      chk(m.mem[a[9:2]], exp);
   endtask
   task automatic cur(input logic [31:0] p, input logic [31:0] r);
      xfer(1'b1, REG_CUR_PROC, p);
      xfer(1'b1, REG_CUR_PRIO, r);
   endtask
   logic [2:0] ops [3] = '{OP_CONDWAIT, OP_WAIT, OP_CONDWAIT};
   logic [31:0] cnts [3] = '{32'h1, 32'h0, 32'h0};
   logic [2:0] ccs [3] = '{CC_SIGNALLED, CC_NONE, CC_NONE};
   initial begin
      repeat (12) @(posedge sysClk);
      rstN <= 1'b1;
      @(posedge sysClk);
      rd(REG_STATUS, 32'h0);
      rd(8'h20, 32'h0);
      xfer(1'b1, REG_SEM_BASE, 32'h300);
      xfer(1'b1, REG_DISP_BASE, 32'h380);
      cur(32'h2, 32'h3);
      m.mem[8'hc0] = 32'h1;
      m.mem[8'hc1] = 32'hfffe;
      m.mem[8'h11] = 32'h25;
      m.mem[8'h21] = 32'h3;
      xfer(1'b1, REG_CMD, {29'h0, OP_SIGNAL});
      repeat (30) @(posedge sysClk);
      rd(REG_STATUS, 32'h1);
      #1 m.mem[8'hc0] = 32'h0;
      fin;
      cm(10'h304, 32'hffff);
      cm(10'h300, 32'h0);
      m.mem[8'hc1] = 32'h2;
      for (int i = 0; i < 3; i++) begin
         op(ops[i]);
         cm(10'h304, cnts[i]);
         if (ops[i] == OP_CONDWAIT) chk({29'h0, q[STAT_CC_LSB+:3]}, {29'h0, ccs[i]});
      end
      cur(32'h1, 32'h5);
      op(OP_WAIT);
      cm(10'h308, 32'h1);
      cm(10'h040, 32'h1);
      rd(REG_CUR_PROC, 32'h0);
      cur(32'h2, 32'h3);
      op(OP_SIGNAL);
      rd(REG_WOKEN, 32'h1);
      cm(10'h308, 32'h0);
      cm(10'h38c, 32'h2);
      cm(10'h394, 32'h0);
      rd(REG_CUR_PROC, 32'h1);
      xfer(1'b1, REG_FLAGS, 32'h1);
      op(OP_WAIT);
      rd(REG_CUR_PROC, 32'h2);
      op(OP_SIGNAL);
      chk(q & 32'h300, 32'h300);
      rd(REG_CUR_PROC, 32'h2);
      cm(10'h394, 32'h1);
      op(OP_RET_INTR);
      rd(REG_CUR_PROC, 32'h1);
      cm(10'h38c, 32'h2);
      m.mem[8'hc2] = 32'h3;
      m.mem[8'h30] = 32'h3;
      m.mem[8'h31] = 32'h24;
      op(OP_SIGNAL);
      cm(10'h390, 32'h3);
      rd(REG_CUR_PROC, 32'h1);
      op(OP_PREEMPT_MSG);
      rd(REG_CUR_PRIO, 32'h5);
      m.mem[8'hc2] = 32'h4;
      m.mem[8'h40] = 32'h4;
      m.mem[8'h41] = 32'h5;
      op(OP_WAIT);
      cm(10'h100, 32'h1);
      cm(10'h040, 32'h4);
      cm(10'h308, 32'h1);
      rd(REG_CUR_PROC, 32'h3);
      endOfTest;
   end
   initial begin
      repeat (30000) @(posedge sysClk);
      errTotal++;
      endOfTest;
   end
endmodule
`default_nettype wire
